// ===== include/drive_map_pkg.sv
/*
 Register map, field positions, message codes and timing counts for the
 drive network command mapper. Assumes a 100 MHz core clock.
*/
package drive_map_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SLOW_SAMPLE_MS = 100;
    localparam int FAST_SAMPLE_MS = 20;
    localparam int SLOW_SAMPLE_CYC = CLK_HZ / 1000 * SLOW_SAMPLE_MS;
    localparam int FAST_SAMPLE_CYC = CLK_HZ / 1000 * FAST_SAMPLE_MS;
    localparam int CNT_W = 24;

    // register numbers (attribute numbers)
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_SEL_SPEED = 8'h01;
    localparam logic [7:0] REG_MOTOR_SPEED = 8'h05;
    localparam logic [7:0] REG_RUN_CTRL = 8'h20;
    localparam logic [7:0] REG_NET_SPEED = 8'h21;

    // explicit path and service codes
    localparam logic [7:0] OBJ_CLASS = 8'hB9;
    localparam logic [7:0] OBJ_INSTANCE = 8'h01;
    localparam logic [7:0] SVC_GET = 8'h0A;
    localparam logic [7:0] SVC_SET = 8'h10;

    // control word fields
    localparam int CW_START = 0;
    localparam int CW_RUN_PERMIT = 1;
    localparam int CW_TUNE_LOAD = 2;

    // status word fields
    localparam int SW_READY = 0;
    localparam int SW_RUNNING = 1;
    localparam int SW_FAULT = 2;
    localparam int SW_FUNC_LOSS = 12;

    localparam logic [1:0] CTRL_SRC_OPTION = 2'h2;
    localparam logic [15:0] SPEED_MAX = 16'h0FFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // explicit answer codes
    localparam logic [1:0] ANS_OK = 2'h0;
    localparam logic [1:0] ANS_BAD_PATH = 2'h1;
    localparam logic [1:0] ANS_BAD_SVC = 2'h2;
    localparam logic [1:0] ANS_READ_ONLY = 2'h3;
endpackage : drive_map_pkg

// ===== logic/drive_net_command_mapper.sv
/*
 Network option card command mapper: turns bit-strobe broadcasts, poll
 control words and explicit get/set requests into drive register traffic
 and gates transfers to the regulator.
 Assumes message decode upstream delivers one-cycle request strobes and
 that the drive side presents its status and terminal inputs as levels.
*/
`timescale 1ns/100ps
`default_nettype none

// Function
// RULE_01: own strobe bit one sets start, permit
// RULE_02: own strobe bit zero stops the drive
// RULE_03: empty strobe acts as zero bit
// RULE_04: master keeps poll connection alive
// RULE_05: regulator samples control every 100/20 ms
// RULE_06: explicit access all registers except control
// RULE_07: path class 185, instance 1, attribute=register
// RULE_08: get service 10, set service 16
// RULE_09: regulator transfer needs option source and poll
// RULE_10: explicit preload allowed before poll exists
// RULE_11: explicit control write with tune bit transfers
// RULE_12: scanner prefers poll for tune load
// RULE_13: ready needs no fault, permit, panel, loss
// RULE_14: control bit 1 is run permit
// RULE_15: selected reference clamped to 0..4095
// RULE_16: controller checks ready before start
// RULE_17: controller starts by edge, stops by permit
// RULE_18: tune bit makes drive accept parameters
// RULE_19: network speed ref sets speed remotely
// RULE_20: status low half run state, high terminals
// RULE_21: strobe bit position equals node address
module drive_net_command_mapper
    import drive_map_pkg::*;
(
    input wire logic CLOCK_I, // 100 MHz clock
    input wire logic RESET_I, // synchronous reset, high
    input wire logic [5:0] NODE_ADDR_I, // network node address
    input wire logic STROBE_VALID_I, // bit-strobe message pulse
    input wire logic [63:0] STROBE_BITS_I, // bit-strobe payload
    input wire logic [3:0] STROBE_LEN_I, // payload byte count
    input wire logic POLL_ACTIVE_I, // poll connection active
    input wire logic POLL_VALID_I, // poll command pulse
    input wire logic [15:0] POLL_CTRL_I, // poll control word
    input wire logic [15:0] POLL_SPEED_I, // poll speed reference
    input wire logic EXP_VALID_I, // explicit request pulse
    input wire logic [7:0] EXP_SERVICE_I, // service code
    input wire logic [7:0] EXP_CLASS_I, // object class
    input wire logic [7:0] EXP_INSTANCE_I, // object instance
    input wire logic [7:0] EXP_ATTR_I, // attribute = register
    input wire logic [15:0] EXP_WDATA_I, // write data
    input wire logic [1:0] CTRL_SOURCE_I, // control-source parameter
    input wire logic TUNING_WRITE_I, // tune data being written
    input wire logic FAULT_ACTIVE_I, // drive fault
    input wire logic RUNNING_I, // drive running
    input wire logic PANEL_STOP_I, // panel stop key pressed
    input wire logic FUNC_LOSS_CLOSED_I, // function loss input closed
    input wire logic [7:0] RUN_STATUS_I, // other run-time status
    input wire logic [3:0] TERMINALS_I, // terminal inputs
    input wire logic [15:0] SPEED_SOURCE_I, // raw selected reference
    input wire logic [15:0] MOTOR_SPEED_I, // scaled output speed
    output logic EXP_DONE_O, // explicit answer pulse
    output logic [1:0] EXP_STATUS_O, // explicit answer code
    output logic [15:0] EXP_RDATA_O, // explicit read data
    output logic [15:0] REG_CTRL_O, // control word to regulator
    output logic [15:0] REG_SPEED_O, // speed ref to regulator
    output logic REG_SAMPLE_O, // regulator sample pulse
    output logic TUNE_TRANSFER_O, // tune/config transfer pulse
    output logic [15:0] STATUS_WORD_O // drive status word
);
    logic [15:0] run_control_word;
    logic [15:0] net_speed_torque_ref;
    logic [15:0] drive_status_word;
    logic [15:0] selected_speed_ref;
    logic [15:0] motor_speed_readout;
    logic [CNT_W-1:0] sample_count;
    logic own_bit;
    logic path_ok;
    logic xfer_ok;
    logic [15:0] read_value;
    logic ctrl_write;
    logic speed_write;

    function automatic logic readable(input logic [7:0] r);
        readable = (r == REG_STATUS) || (r == REG_SEL_SPEED)
            || (r == REG_MOTOR_SPEED) || (r == REG_NET_SPEED);
    endfunction : readable

    // set request on a valid path to one given register
    function automatic logic set_hit(input logic [7:0] svc,
        input logic path, input logic [7:0] attr, input logic [7:0] r);
        set_hit = path && (svc == SVC_SET) && (attr == r);
    endfunction : set_hit

    // empty payload counts as zero bit
    assign own_bit = (STROBE_LEN_I != 4'h0) && STROBE_BITS_I[NODE_ADDR_I]; // RULE_03 RULE_21
    assign path_ok = (EXP_CLASS_I == OBJ_CLASS)
        && (EXP_INSTANCE_I == OBJ_INSTANCE); // RULE_07
    assign xfer_ok = (CTRL_SOURCE_I == CTRL_SRC_OPTION) && POLL_ACTIVE_I; // RULE_09
    // explicit control write only while no poll owns the word
    assign ctrl_write = EXP_VALID_I && !POLL_ACTIVE_I
        && set_hit(EXP_SERVICE_I, path_ok, EXP_ATTR_I, REG_RUN_CTRL);
    assign speed_write = EXP_VALID_I
        && set_hit(EXP_SERVICE_I, path_ok, EXP_ATTR_I, REG_NET_SPEED);

    // run control word: strobe overrides poll in the same cycle
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
            run_control_word <= WORD_ZERO;
        else if (STROBE_VALID_I)
        begin
            if (own_bit)
            begin
                run_control_word[CW_START] <= 1'b1; // RULE_01
                run_control_word[CW_RUN_PERMIT] <= 1'b1; // RULE_01 RULE_14
            end
            else
            begin
                run_control_word[CW_START] <= 1'b0; // RULE_02
                run_control_word[CW_RUN_PERMIT] <= 1'b0; // RULE_02
            end
        end
        else if (POLL_VALID_I)
            run_control_word <= POLL_CTRL_I;
        else if (ctrl_write)
            run_control_word <= EXP_WDATA_I;
    end

    // network speed reference: poll or explicit preload
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
            net_speed_torque_ref <= WORD_ZERO;
        else if (POLL_VALID_I)
            net_speed_torque_ref <= POLL_SPEED_I;
        else if (speed_write)
            net_speed_torque_ref <= EXP_WDATA_I; // RULE_10 RULE_06
    end

    // status, reference and speed readouts
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            drive_status_word <= WORD_ZERO;
            selected_speed_ref <= WORD_ZERO;
            motor_speed_readout <= WORD_ZERO;
        end
        else
        begin
            drive_status_word <= {3'h0, FUNC_LOSS_CLOSED_I, TERMINALS_I,
                RUN_STATUS_I[7:3], FAULT_ACTIVE_I, RUNNING_I,
                !FAULT_ACTIVE_I && run_control_word[CW_RUN_PERMIT]
                && !PANEL_STOP_I && FUNC_LOSS_CLOSED_I}; // RULE_13 RULE_20
            selected_speed_ref <= (SPEED_SOURCE_I > SPEED_MAX)
                ? SPEED_MAX : SPEED_SOURCE_I; // RULE_15
            motor_speed_readout <= MOTOR_SPEED_I;
        end
    end

    always_comb
    begin
        case (EXP_ATTR_I)
            REG_STATUS: read_value = drive_status_word;
            REG_SEL_SPEED: read_value = selected_speed_ref;
            REG_MOTOR_SPEED: read_value = motor_speed_readout;
            REG_NET_SPEED: read_value = net_speed_torque_ref;
            default: read_value = WORD_ZERO;
        endcase
    end

    // explicit answers
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            EXP_DONE_O <= 1'b0;
            EXP_STATUS_O <= ANS_OK;
            EXP_RDATA_O <= WORD_ZERO;
        end
        else
        begin
            EXP_DONE_O <= EXP_VALID_I;
            if (EXP_VALID_I)
            begin
                EXP_RDATA_O <= WORD_ZERO;
                if (!path_ok)
                    EXP_STATUS_O <= ANS_BAD_PATH; // RULE_07
                else if (EXP_SERVICE_I == SVC_GET)
                begin
                    if (readable(EXP_ATTR_I)) // RULE_06 RULE_08
                    begin
                        EXP_STATUS_O <= ANS_OK;
                        EXP_RDATA_O <= read_value;
                    end
                    else
                        EXP_STATUS_O <= ANS_BAD_PATH;
                end
                else if (EXP_SERVICE_I == SVC_SET)
                begin
                    if (EXP_ATTR_I == REG_NET_SPEED)
                        EXP_STATUS_O <= ANS_OK; // RULE_08
                    else if (EXP_ATTR_I == REG_RUN_CTRL && !POLL_ACTIVE_I)
                        EXP_STATUS_O <= ANS_OK;
                    else if (readable(EXP_ATTR_I)
                        || EXP_ATTR_I == REG_RUN_CTRL)
                        EXP_STATUS_O <= ANS_READ_ONLY; // RULE_06
                    else
                        EXP_STATUS_O <= ANS_BAD_PATH;
                end
                else
                    EXP_STATUS_O <= ANS_BAD_SVC; // RULE_08
            end
        end
    end

    // regulator sampling period
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            sample_count <= '0;
            REG_SAMPLE_O <= 1'b0;
        end
        else if (sample_count == CNT_W'(0))
        begin
            sample_count <= TUNING_WRITE_I
                ? CNT_W'(SLOW_SAMPLE_CYC - 1)
                : CNT_W'(FAST_SAMPLE_CYC - 1); // RULE_05
            REG_SAMPLE_O <= 1'b1;
        end
        else
        begin
            sample_count <= sample_count - CNT_W'(1);
            REG_SAMPLE_O <= 1'b0;
        end
    end

    // regulator inputs and tune transfer
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            REG_CTRL_O <= WORD_ZERO;
            REG_SPEED_O <= WORD_ZERO;
            TUNE_TRANSFER_O <= 1'b0;
            STATUS_WORD_O <= WORD_ZERO;
        end
        else
        begin
            STATUS_WORD_O <= drive_status_word;
            if (REG_SAMPLE_O && xfer_ok) // RULE_05 RULE_09
            begin
                REG_CTRL_O <= run_control_word;
                REG_SPEED_O <= net_speed_torque_ref; // RULE_19
            end
            TUNE_TRANSFER_O <= (POLL_VALID_I && xfer_ok
                && POLL_CTRL_I[CW_TUNE_LOAD]) // RULE_18
                || (ctrl_write && EXP_WDATA_I[CW_TUNE_LOAD]); // RULE_11
        end
    end
endmodule : drive_net_command_mapper

`default_nettype wire

// ===== verification/drive_map_checker_sva.sv
/*
 Port checker for the drive command mapper.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_map_checker
    import drive_map_pkg::*;
(
    input wire logic CLOCK_I, RESET_I, STROBE_VALID_I, POLL_VALID_I,
    input wire logic EXP_VALID_I, POLL_ACTIVE_I, FAULT_ACTIVE_I,
    input wire logic PANEL_STOP_I, FUNC_LOSS_CLOSED_I, EXP_DONE_O,
    input wire logic TUNE_TRANSFER_O,
    input wire logic [1:0] EXP_STATUS_O,
    input wire logic [3:0] STROBE_LEN_I, TERMINALS_I,
    input wire logic [5:0] NODE_ADDR_I,
    input wire logic [7:0] EXP_SERVICE_I, EXP_CLASS_I, EXP_INSTANCE_I,
    input wire logic [7:0] EXP_ATTR_I,
    input wire logic [15:0] EXP_WDATA_I, STATUS_WORD_O,
    input wire logic [63:0] STROBE_BITS_I
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);
    logic quiet, ready_in, path_ok, ctrl_set;
    assign quiet = !STROBE_VALID_I && !POLL_VALID_I && !EXP_VALID_I;
    assign ready_in = !FAULT_ACTIVE_I && !PANEL_STOP_I && FUNC_LOSS_CLOSED_I;
    assign path_ok = EXP_CLASS_I == OBJ_CLASS
        && EXP_INSTANCE_I == OBJ_INSTANCE;
    assign ctrl_set = EXP_VALID_I && path_ok && EXP_SERVICE_I == SVC_SET
        && EXP_ATTR_I == REG_RUN_CTRL;
    sequence s_go;
        STROBE_VALID_I && STROBE_LEN_I == 4'h8 && STROBE_BITS_I[NODE_ADDR_I];
    endsequence
    sequence s_stop;
        STROBE_VALID_I && (STROBE_LEN_I == 4'h0
            || STROBE_LEN_I == 4'h8 && !STROBE_BITS_I[NODE_ADDR_I]);
    endsequence
    strobe_start_a:
        assert property (s_go ##1 (quiet && ready_in) [*2]
            |=> STATUS_WORD_O[SW_READY])
        else $error("own strobe bit did not ready the drive");
    strobe_stop_a:
        assert property (s_stop ##1 quiet [*2] |=> !STATUS_WORD_O[SW_READY])
        else $error("stop strobe left drive ready");
    answer_timing_a:
        assert property (EXP_DONE_O == $past(EXP_VALID_I))
        else $error("answer pulse off by a cycle");
    path_refuse_a:
        assert property (EXP_VALID_I && !path_ok && EXP_SERVICE_I == SVC_GET
            |=> EXP_STATUS_O == ANS_BAD_PATH)
        else $error("wrong path not refused");
    ctrl_guard_a:
        assert property (ctrl_set && POLL_ACTIVE_I
            |=> EXP_STATUS_O == ANS_READ_ONLY)
        else $error("control set under poll not refused");
    tune_pulse_a:
        assert property (ctrl_set && !POLL_ACTIVE_I
            && EXP_WDATA_I[CW_TUNE_LOAD] |-> ##[1:2] TUNE_TRANSFER_O)
        else $error("no tune transfer pulse");
    ready_cause_a:
        assert property (STATUS_WORD_O[SW_READY] |-> $past(ready_in, 2))
        else $error("ready while a condition fails");
    status_map_a:
        assert property (!$past(RESET_I) && !$past(RESET_I, 2)
            |-> STATUS_WORD_O[15:8]
            == $past({3'h0, FUNC_LOSS_CLOSED_I, TERMINALS_I}, 2))
        else $error("status high half wrong");
endmodule : drive_map_checker
bind drive_net_command_mapper drive_map_checker chk_u (.*);
`default_nettype wire

// ===== verification/scanner_model.sv
/*
 Scanner model: issues explicit get and set requests one at a time.
 Assumes the card takes a request on the edge where it is valid.
*/
`timescale 1ns/100ps
`default_nettype none
module scanner_model (
    input wire logic clk_i, // core clock
    output logic valid_o, // request pulse
    output logic [7:0] svc_o, // service code
    output logic [7:0] cls_o, // object class
    output logic [7:0] ins_o, // object instance
    output logic [7:0] att_o, // attribute
    output logic [15:0] wd_o // write data
);
    initial
    begin
        valid_o = 1'b0;
        {svc_o, cls_o, ins_o, att_o, wd_o} = '0;
    end
    task request(input logic [7:0] s, c, i, a, input logic [15:0] w);
        @(posedge clk_i);
        valid_o <= 1'b1;
        {svc_o, cls_o, ins_o, att_o, wd_o} <= {s, c, i, a, w};
        @(posedge clk_i);
        valid_o <= 1'b0;
        {svc_o, cls_o, ins_o, att_o, wd_o} <= ~{s, c, i, a, w};
        #1;
    endtask : request
endmodule : scanner_model
`default_nettype wire

// ===== verification/drive_net_command_mapper_tb.sv
/*
 Bench for the drive command mapper: status, poll and strobe control,
 explicit access. Assumes the scanner model drives explicit requests.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_net_command_mapper_tb
    import drive_map_pkg::*;
;
    logic CLOCK_I, RESET_I, STROBE_VALID_I, POLL_ACTIVE_I, POLL_VALID_I;
    logic TUNING_WRITE_I, FAULT_ACTIVE_I, RUNNING_I, PANEL_STOP_I;
    logic FUNC_LOSS_CLOSED_I, EXP_VALID_I, EXP_DONE_O, REG_SAMPLE_O;
    logic TUNE_TRANSFER_O;
    logic [1:0] CTRL_SOURCE_I, EXP_STATUS_O;
    logic [3:0] STROBE_LEN_I, TERMINALS_I;
    logic [5:0] NODE_ADDR_I;
    logic [7:0] RUN_STATUS_I, EXP_SERVICE_I, EXP_CLASS_I, EXP_INSTANCE_I;
    logic [7:0] EXP_ATTR_I;
    logic [15:0] POLL_CTRL_I, POLL_SPEED_I, EXP_WDATA_I, SPEED_SOURCE_I;
    logic [15:0] MOTOR_SPEED_I, EXP_RDATA_O, REG_CTRL_O, REG_SPEED_O;
    logic [15:0] STATUS_WORD_O;
    logic [63:0] STROBE_BITS_I;
    int failures, n_tests, tunes, samples;
    drive_net_command_mapper dut_u (.*);
    scanner_model scan_u (.clk_i(CLOCK_I), .valid_o(EXP_VALID_I),
        .svc_o(EXP_SERVICE_I), .cls_o(EXP_CLASS_I), .ins_o(EXP_INSTANCE_I),
        .att_o(EXP_ATTR_I), .wd_o(EXP_WDATA_I));
    initial
    begin
        CLOCK_I = 1'b0;
        forever #5 CLOCK_I = ~CLOCK_I;
    end
    always @(posedge CLOCK_I) tunes <= tunes + int'(TUNE_TRANSFER_O);
    always @(posedge CLOCK_I) samples <= samples + int'(REG_SAMPLE_O);
    task chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic [7:0] s, c, a, input logic [15:0] w,
        input logic [1:0] st);
        scan_u.request(s, c, OBJ_INSTANCE, a, w);
        chk(16'(EXP_DONE_O), 16'h0001);
        chk(16'(EXP_STATUS_O), 16'(st));
    endtask : xfer
    // one strobe or poll command, then the ready bit three clocks after it is taken
    task beat(input logic strobe, input logic [63:0] b,
        input logic [3:0] n, cond, input logic rdy);
        @(posedge CLOCK_I);
        STROBE_VALID_I <= strobe;
        POLL_VALID_I <= !strobe;
        TUNING_WRITE_I <= strobe;
        {STROBE_BITS_I, STROBE_LEN_I, POLL_CTRL_I} <= {b, n, b[15:0]};
        {FAULT_ACTIVE_I, PANEL_STOP_I, FUNC_LOSS_CLOSED_I, RUNNING_I} <= cond;
        @(posedge CLOCK_I);
        {STROBE_VALID_I, POLL_VALID_I} <= 2'b00;
        STROBE_BITS_I <= ~b;
        repeat (3) @(posedge CLOCK_I);
        #1 chk(16'(STATUS_WORD_O[SW_READY]), 16'(rdy));
    endtask : beat
    task end_of_test;
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial
    begin
        RESET_I = 1'b1;
        {STROBE_VALID_I, POLL_VALID_I, TUNING_WRITE_I} = 3'b000;
        {FAULT_ACTIVE_I, PANEL_STOP_I, FUNC_LOSS_CLOSED_I, RUNNING_I} = 4'h3;
        {STROBE_LEN_I, STROBE_BITS_I, POLL_CTRL_I, POLL_SPEED_I} = '0;
        POLL_ACTIVE_I = 1'b1;
        CTRL_SOURCE_I = CTRL_SRC_OPTION;
        NODE_ADDR_I = 6'h09;
        RUN_STATUS_I = 8'h18;
        TERMINALS_I = 4'hA;
        SPEED_SOURCE_I = 16'h2000;
        MOTOR_SPEED_I = 16'h0123;
        repeat (12) @(posedge CLOCK_I);
        RESET_I <= 1'b0;
        repeat (4) @(posedge CLOCK_I);
        #1 chk(STATUS_WORD_O, 16'h1A1A);
        beat(1'b0, 64'h2, 4'h0, 4'h3, 1'b1);
        beat(1'b0, 64'h2, 4'h0, 4'hB, 1'b0);
        beat(1'b0, 64'h2, 4'h0, 4'h7, 1'b0);
        beat(1'b0, 64'h2, 4'h0, 4'h1, 1'b0);
        beat(1'b1, 64'hFFFF_FFFF_FFFF_FDFF, 4'h8, 4'h3, 1'b0);
        beat(1'b1, 64'h200, 4'h8, 4'h3, 1'b1);
        beat(1'b1, 64'h200, 4'h0, 4'h3, 1'b0);
        beat(1'b0, 64'h6, 4'h0, 4'h3, 1'b1);
        chk(16'(tunes), 16'h0001);
        @(posedge CLOCK_I);
        POLL_ACTIVE_I <= 1'b0;
        xfer(SVC_SET, OBJ_CLASS, REG_NET_SPEED, 16'h0FFF, ANS_OK);
        xfer(SVC_GET, OBJ_CLASS, REG_NET_SPEED, 16'h0000, ANS_OK);
        chk(EXP_RDATA_O, 16'h0FFF);
        xfer(SVC_GET, OBJ_CLASS, REG_SEL_SPEED, 16'h0000, ANS_OK);
        chk(EXP_RDATA_O, SPEED_MAX);
        xfer(SVC_GET, OBJ_CLASS, REG_MOTOR_SPEED, 16'h0000, ANS_OK);
        chk(EXP_RDATA_O, 16'h0123);
        xfer(SVC_GET, 8'hB8, REG_STATUS, 16'h0000, ANS_BAD_PATH);
        xfer(8'h0E, OBJ_CLASS, REG_STATUS, 16'h0000, ANS_BAD_SVC);
        xfer(SVC_SET, OBJ_CLASS, REG_RUN_CTRL, 16'h0006, ANS_OK);
        repeat (2) @(posedge CLOCK_I);
        #1 chk(16'(tunes), 16'h0002);
        @(posedge CLOCK_I);
        POLL_ACTIVE_I <= 1'b1;
        xfer(SVC_SET, OBJ_CLASS, REG_RUN_CTRL, 16'h0000, ANS_READ_ONLY);
        repeat (3) @(posedge CLOCK_I);
        #1 chk(16'(STATUS_WORD_O[SW_READY]), 16'h0001);
        chk(16'(samples), 16'h0001);
        end_of_test();
    end
endmodule : drive_net_command_mapper_tb
`default_nettype wire
